// *** rtl/pfsm_pkg.sv ***
// package: register map, field layout, variants and carriers for the pin function mux
package pfsm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FIELD_W = 2;
  localparam int WORD_LSB = 2;
  localparam logic [ADDR_W-1:0] SRC_SEL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PA_FUNC_OFS = 8'h04;
  localparam logic [5:0] SRC_SEL_RST = 6'h00;
  localparam logic [7:0] PA_FUNC_RST = 8'h00;
  localparam int SDI_LSB = 4;
  localparam int SCK_LSB = 2;
  localparam int RX_LSB = 0;
  localparam int PA3_LSB = 6;
  localparam int PA2_LSB = 4;
  localparam int PA1_LSB = 2;
  localparam int PA0_LSB = 0;
  localparam logic [1:0] VAR_FIRST = 2'h0;
  localparam logic [1:0] VAR_SECOND = 2'h1;
  localparam logic [1:0] VAR_THIRD = 2'h2;
  localparam logic [1:0] CODE_00 = 2'h0;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] CODE_10 = 2'h2;
  localparam logic [1:0] CODE_11 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WR_IDLE = 2'h1, WR_RESP = 2'h2} pfsm_wr_e;
  typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_DATA = 2'h2} pfsm_rd_e;
  typedef enum logic [1:0] {SRC_SDI = 2'h0, SRC_SCK = 2'h1, SRC_RX = 2'h2} pfsm_src_e;
  typedef struct packed {
    logic port_a_pin1;
    logic port_a_pin5;
    logic port_a_pin6;
    logic port_a_pin7;
    logic port_b_pin0;
    logic port_b_pin1;
    logic port_b_pin3;
    logic port_f_pin3;
    logic port_f_pin4;
    logic port_f_pin5;
  } pfsm_pad_s;
  typedef struct packed {
    logic pa3_gpio;
    logic pa3_slave_sel;
    logic pa3_xtal1;
    logic pa2_gpio;
    logic pa2_slave_sel;
    logic pa1_gpio;
    logic pa1_timer0;
    logic pa1_uart_rx;
    logic pa1_serial_clk;
    logic pa0_gpio;
    logic pa0_sdo;
  } pfsm_func_s;
  typedef struct packed {
    logic sdo;
    logic timer0;
    logic sck;
    logic sck_oe_n;
  } pfsm_periph_s;
endpackage

// *** rtl/pfsm_top.sv ***
// pin function select mux: register slave, input source routing and port a pin functions
// Summary of operation
// - First variant: serial data input takes port b pin 0 for codes 00/10 and port a pin 5 for 01/11.
// - First variant: serial clock input takes port b pin 1 for 00/01 and port a pin 1 for 10/11.
// - First variant: uart receive takes port b pin 3 for 00/01 and port a pin 1 for 10/11.
// - Second variant: serial data takes pb0, pa5, pa7, pb0 for codes 00, 01, 10, 11.
// - Second variant: serial clock takes pb1, pa1, pa6, pb1 for codes 00, 01, 10, 11.
// - Second variant: uart receive takes pb3, pa1, pa6, pb3 for codes 00, 01, 10, 11.
// - Third variant: serial data takes port b pin 0 for 00/10 and port f pin 3 for 01/11.
// - Third variant: serial clock takes pb1, pf5, pf4, pb1 for codes 00, 01, 10, 11.
// - Third variant: uart receive takes pb3, pf5, pf4, pb3 for codes 00, 01, 10, 11.
// - Bits 7 and 6 of the input source register are not stored and read as zero.
// - Port a pin 3 is general io for 00/11, slave select for 01 and crystal input one for 10.
// - In the second and third variants port a pin 2 is slave select for 01, else general io.
// - Port a pin 1 is io for 00, timer zero for 01, and rx/serial clock for 10/11 except io in the third.
// - Port a pin 0 is the serial data output for 01 and general io otherwise.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pfsm_top #(
  parameter logic [1:0] VARIANT = pfsm_pkg::VAR_FIRST
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [pfsm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pfsm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pfsm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pfsm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire pfsm_pkg::pfsm_pad_s pads,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe_n,
  input wire pfsm_pkg::pfsm_periph_s periph,
  output logic serial_data_in,
  output logic serial_clock_in,
  output logic uart_rx_in,
  output pfsm_pkg::pfsm_func_s pa_func,
  output logic [3:0] pa_pad_out,
  output logic [3:0] pa_pad_oe_n
);
  import pfsm_pkg::*;

  pfsm_wr_e wr_state_r;
  pfsm_rd_e rd_state_r;
  logic awready_r;
  logic wready_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic rd_src_r;
  logic [5:0] src_sel_r;
  logic [7:0] pa_func_r;
  logic serial_data_in_r;
  logic serial_clock_in_r;
  logic uart_rx_in_r;
  pfsm_func_s pa_func_nxt;
  pfsm_func_s pa_func_out_r;
  logic [3:0] pa_pad_out_r;
  logic [3:0] pa_pad_oe_n_r;
  logic wr_commit;
  logic [DATA_W-1:0] rd_value;

  function automatic logic is_src(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:WORD_LSB] == SRC_SEL_OFS[ADDR_W-1:WORD_LSB];
  endfunction

  function automatic logic is_pa(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:WORD_LSB] == PA_FUNC_OFS[ADDR_W-1:WORD_LSB];
  endfunction

  // one table per variant, picked at build time
  function automatic logic route_input(
    input logic [1:0] variant,
    input pfsm_src_e kind,
    input logic [1:0] code,
    input pfsm_pad_s pd
  );
    logic bit_v;
    bit_v = pd.port_b_pin0;
    case (kind)
      SRC_SDI:
      begin
        if (variant == VAR_SECOND)
        begin
          case (code)
            CODE_01: bit_v = pd.port_a_pin5;
            CODE_10: bit_v = pd.port_a_pin7;
            default: bit_v = pd.port_b_pin0;
          endcase
        end
        else if (variant == VAR_THIRD)
          bit_v = code[0] ? pd.port_f_pin3 : pd.port_b_pin0;
        else
          bit_v = code[0] ? pd.port_a_pin5 : pd.port_b_pin0;
      end
      SRC_SCK:
      begin
        if (variant == VAR_SECOND)
        begin
          case (code)
            CODE_01: bit_v = pd.port_a_pin1;
            CODE_10: bit_v = pd.port_a_pin6;
            default: bit_v = pd.port_b_pin1;
          endcase
        end
        else if (variant == VAR_THIRD)
        begin
          case (code)
            CODE_01: bit_v = pd.port_f_pin5;
            CODE_10: bit_v = pd.port_f_pin4;
            default: bit_v = pd.port_b_pin1;
          endcase
        end
        else
          bit_v = code[1] ? pd.port_a_pin1 : pd.port_b_pin1;
      end
      default:
      begin
        if (variant == VAR_SECOND)
        begin
          case (code)
            CODE_01: bit_v = pd.port_a_pin1;
            CODE_10: bit_v = pd.port_a_pin6;
            default: bit_v = pd.port_b_pin3;
          endcase
        end
        else if (variant == VAR_THIRD)
        begin
          case (code)
            CODE_01: bit_v = pd.port_f_pin5;
            CODE_10: bit_v = pd.port_f_pin4;
            default: bit_v = pd.port_b_pin3;
          endcase
        end
        else
          bit_v = code[1] ? pd.port_a_pin1 : pd.port_b_pin3;
      end
    endcase
    return bit_v;
  endfunction

  assign wr_commit = (wr_state_r == WR_IDLE) && aw_hold_r && w_hold_r;

  always_comb
  begin
    rd_value = '0;
    if (is_src(araddr))
      rd_value = {26'h000_0000, src_sel_r};
    else if (is_pa(araddr))
      rd_value = {24'h00_0000, pa_func_r};
  end

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_r <= WR_IDLE;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (ce)
    begin
      case (wr_state_r)
        WR_IDLE:
        begin
          if (awvalid && awready_r)
          begin
            aw_hold_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= awaddr;
          end
          if (wvalid && wready_r)
          begin
            w_hold_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= wdata[7:0];
            wstrb_r <= wstrb[0];
          end
          if (wr_commit)
          begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (is_src(awaddr_r) || is_pa(awaddr_r)) ? RESP_OKAY : RESP_SLVERR;
            wr_state_r <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (bready)
          begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            wr_state_r <= WR_IDLE;
          end
        end
        default: wr_state_r <= WR_IDLE;
      endcase
    end
  end

  // read channel: one read at a time, data sampled at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_r <= RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      rd_src_r <= 1'b0;
    end
    else if (ce)
    begin
      case (rd_state_r)
        RD_IDLE:
        begin
          if (arvalid && arready_r)
          begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_value;
            rd_src_r <= is_src(araddr);
            rresp_r <= (is_src(araddr) || is_pa(araddr)) ? RESP_OKAY : RESP_SLVERR;
            rd_state_r <= RD_DATA;
          end
        end
        RD_DATA:
        begin
          if (rready)
          begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
            rd_state_r <= RD_IDLE;
          end
        end
        default: rd_state_r <= RD_IDLE;
      endcase
    end
  end

  // select registers; only byte lane 0 carries the 6-bit and 8-bit fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_sel_r <= SRC_SEL_RST;
      pa_func_r <= PA_FUNC_RST;
    end
    else if (ce && wr_commit && wstrb_r)
    begin
      if (is_src(awaddr_r))
        src_sel_r <= wdata_r[5:0];
      else if (is_pa(awaddr_r))
        pa_func_r <= wdata_r;
    end
  end

  // registered routing costs one cycle of latency on each serial input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_data_in_r <= 1'b0;
      serial_clock_in_r <= 1'b0;
      uart_rx_in_r <= 1'b0;
    end
    else if (ce)
    begin
      serial_data_in_r <= route_input(VARIANT, SRC_SDI, src_sel_r[SDI_LSB +: FIELD_W], pads);
      serial_clock_in_r <= route_input(VARIANT, SRC_SCK, src_sel_r[SCK_LSB +: FIELD_W], pads);
      uart_rx_in_r <= route_input(VARIANT, SRC_RX, src_sel_r[RX_LSB +: FIELD_W], pads);
    end
  end

  always_comb
  begin
    pa_func_nxt = '0;
    case (pa_func_r[PA3_LSB +: FIELD_W])
      CODE_01: pa_func_nxt.pa3_slave_sel = 1'b1;
      CODE_10: pa_func_nxt.pa3_xtal1 = 1'b1;
      default: pa_func_nxt.pa3_gpio = 1'b1;
    endcase
    // first variant has no pin 2 peripheral, so the field is storage only there
    if (VARIANT != VAR_FIRST && pa_func_r[PA2_LSB +: FIELD_W] == CODE_01)
      pa_func_nxt.pa2_slave_sel = 1'b1;
    else
      pa_func_nxt.pa2_gpio = 1'b1;
    case (pa_func_r[PA1_LSB +: FIELD_W])
      CODE_01: pa_func_nxt.pa1_timer0 = 1'b1;
      CODE_10:
      begin
        if (VARIANT == VAR_THIRD)
          pa_func_nxt.pa1_gpio = 1'b1;
        else
          pa_func_nxt.pa1_uart_rx = 1'b1;
      end
      CODE_11:
      begin
        if (VARIANT == VAR_THIRD)
          pa_func_nxt.pa1_gpio = 1'b1;
        else
          pa_func_nxt.pa1_serial_clk = 1'b1;
      end
      default: pa_func_nxt.pa1_gpio = 1'b1;
    endcase
    if (pa_func_r[PA0_LSB +: FIELD_W] == CODE_01)
      pa_func_nxt.pa0_sdo = 1'b1;
    else
      pa_func_nxt.pa0_gpio = 1'b1;
  end

  // pad drivers; input-only functions release the pad
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pa_func_out_r <= '0;
      pa_pad_out_r <= 4'h0;
      pa_pad_oe_n_r <= 4'hf;
    end
    else if (ce)
    begin
      pa_func_out_r <= pa_func_nxt;
      pa_pad_out_r[0] <= pa_func_nxt.pa0_sdo ? periph.sdo : gpio_out[0];
      pa_pad_oe_n_r[0] <= pa_func_nxt.pa0_sdo ? 1'b0 : gpio_oe_n[0];
      if (pa_func_nxt.pa1_timer0)
      begin
        pa_pad_out_r[1] <= periph.timer0;
        pa_pad_oe_n_r[1] <= 1'b0;
      end
      else if (pa_func_nxt.pa1_serial_clk)
      begin
        pa_pad_out_r[1] <= periph.sck;
        pa_pad_oe_n_r[1] <= periph.sck_oe_n;
      end
      else
      begin
        pa_pad_out_r[1] <= gpio_out[1];
        pa_pad_oe_n_r[1] <= pa_func_nxt.pa1_uart_rx | gpio_oe_n[1];
      end
      pa_pad_out_r[2] <= gpio_out[2];
      pa_pad_oe_n_r[2] <= pa_func_nxt.pa2_slave_sel | gpio_oe_n[2];
      pa_pad_out_r[3] <= gpio_out[3];
      pa_pad_oe_n_r[3] <= ~pa_func_nxt.pa3_gpio | gpio_oe_n[3];
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign serial_data_in = serial_data_in_r;
  assign serial_clock_in = serial_clock_in_r;
  assign uart_rx_in = uart_rx_in_r;
  assign pa_func = pa_func_out_r;
  assign pa_pad_out = pa_pad_out_r;
  assign pa_pad_oe_n = pa_pad_oe_n_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  first_sdi_route_a: assert property (VARIANT == VAR_FIRST && ce && src_sel_r[5:4] == CODE_01
    |=> serial_data_in_r == $past(pads.port_a_pin5)) else $error("sdi route wrong");
  first_sck_route_a: assert property (VARIANT == VAR_FIRST && ce && src_sel_r[3:2] == CODE_01
    |=> serial_clock_in_r == $past(pads.port_b_pin1)) else $error("sck route wrong");
  first_rx_route_a: assert property (VARIANT == VAR_FIRST && ce && src_sel_r[1:0] == CODE_10
    |=> uart_rx_in_r == $past(pads.port_a_pin1)) else $error("rx route wrong");
  second_sdi_route_a: assert property (VARIANT == VAR_SECOND && ce && src_sel_r[5:4] == CODE_10
    |=> serial_data_in_r == $past(pads.port_a_pin7)) else $error("sdi route wrong");
  second_sck_route_a: assert property (VARIANT == VAR_SECOND && ce && src_sel_r[3:2] == CODE_10
    |=> serial_clock_in_r == $past(pads.port_a_pin6)) else $error("sck route wrong");
  second_rx_route_a: assert property (VARIANT == VAR_SECOND && ce && src_sel_r[1:0] == CODE_11
    |=> uart_rx_in_r == $past(pads.port_b_pin3)) else $error("rx route wrong");
  third_sdi_route_a: assert property (VARIANT == VAR_THIRD && ce && src_sel_r[5:4] == CODE_11
    |=> serial_data_in_r == $past(pads.port_f_pin3)) else $error("sdi route wrong");
  third_sck_route_a: assert property (VARIANT == VAR_THIRD && ce && src_sel_r[3:2] == CODE_01
    |=> serial_clock_in_r == $past(pads.port_f_pin5)) else $error("sck route wrong");
  third_rx_route_a: assert property (VARIANT == VAR_THIRD && ce && src_sel_r[1:0] == CODE_10
    |=> uart_rx_in_r == $past(pads.port_f_pin4)) else $error("rx route wrong");
  src_high_zero_a: assert property (rvalid_r && rd_src_r |-> rdata_r[31:6] == 26'h000_0000)
    else $error("source register upper bits not zero");
  pin3_xtal_a: assert property (ce && pa_func_r[7:6] == CODE_10
    |=> pa_func_out_r.pa3_xtal1 && pa_pad_oe_n_r[3]) else $error("pin 3 crystal select wrong");
  pin2_sel_a: assert property (ce && pa_func_r[5:4] == CODE_01
    |=> pa_func_out_r.pa2_slave_sel == (VARIANT != VAR_FIRST)) else $error("pin 2 select wrong");
  pin1_func_a: assert property (ce && pa_func_r[3:2] == CODE_11
    |=> pa_func_out_r.pa1_gpio == (VARIANT == VAR_THIRD)) else $error("pin 1 select wrong");
  pin0_sdo_a: assert property (ce && pa_func_r[1:0] == CODE_01
    |=> pa_pad_out_r[0] == $past(periph.sdo) && !pa_pad_oe_n_r[0]) else $error("pin 0 sdo wrong");
  reset_value_a: assert property ($rose(aresetn) |-> src_sel_r == SRC_SEL_RST
    && pa_func_r == PA_FUNC_RST) else $error("select fields not reset");
  write_resp_a: assert property (ce && wr_commit |=> bvalid_r) else $error("missing write response");

  write_done_c: cover property (bvalid_r && bready && bresp_r == RESP_OKAY);
  read_src_c: cover property (rvalid_r && rready && rd_src_r);
  sdo_pin_c: cover property (pa_func_out_r.pa0_sdo);
  unmapped_c: cover property (rvalid_r && rresp_r == RESP_SLVERR);
endmodule // pfsm_top
`default_nettype wire

// *** tb/pfsm_pad_model.sv ***
// far-side model: pad levels and peripheral drive seen by the pin function mux
`timescale 1ns/1ps
`default_nettype none
module pfsm_pad_model (
  input wire logic aclk,
  input wire logic [9:0] pad_pat,
  input wire logic [3:0] per_pat,
  output var pfsm_pkg::pfsm_pad_s pads,
  output var pfsm_pkg::pfsm_periph_s periph
);
  import pfsm_pkg::*;
  // pads are synchronous levels, so they move one edge after the bench asks
  always @(posedge aclk)
  begin
    pads <= pfsm_pad_s'(pad_pat);
    periph <= pfsm_periph_s'(per_pat);
  end
endmodule // pfsm_pad_model
`default_nettype wire

// *** tb/tb_pfsm_top.sv ***
// testbench: three variants side by side, register access, routing and pin functions
`timescale 1ns/1ps
`default_nettype none
module tb_pfsm_top;
  import pfsm_pkg::*;
  // pad index in the pad struct for [variant][input][code]: sdi, sck, rx
  localparam int ROUTE [3][3][4] = '{
    '{'{5, 8, 5, 8}, '{4, 4, 9, 9}, '{3, 3, 9, 9}},
    '{'{5, 8, 6, 5}, '{4, 9, 7, 4}, '{3, 9, 7, 3}},
    '{'{5, 2, 5, 2}, '{4, 0, 1, 4}, '{3, 0, 1, 3}}};
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb, gpio_out, gpio_oe_n, per_pat;
  logic [9:0] pad_pat;
  pfsm_pad_s pads;
  pfsm_periph_s periph;
  logic awready [3], wready [3], bvalid [3], arready [3], rvalid [3];
  logic sdi [3], sck [3], rx [3];
  logic [1:0] bresp [3], rresp [3], wr_r [3], rd_r [3];
  logic [31:0] rdata [3], rd_d [3];
  pfsm_func_s pa_func [3];
  logic [3:0] pa_pad_out [3], pa_pad_oe_n [3];
  int bad_count = 0;
  int n_checks = 0;

  pfsm_pad_model far_side (.aclk(aclk), .pad_pat(pad_pat), .per_pat(per_pat),
    .pads(pads), .periph(periph));

  for (genvar i = 0; i < 3; i++)
  begin : g_var
    pfsm_top #(.VARIANT(2'(i))) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready[i]), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready[i]), .bresp(bresp[i]),
      .bvalid(bvalid[i]), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready[i]), .rdata(rdata[i]), .rresp(rresp[i]), .rvalid(rvalid[i]),
      .rready(rready), .pads(pads), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .periph(periph), .serial_data_in(sdi[i]), .serial_clock_in(sck[i]),
      .uart_rx_in(rx[i]), .pa_func(pa_func[i]), .pa_pad_out(pa_pad_out[i]),
      .pa_pad_oe_n(pa_pad_oe_n[i]));
  end

  initial
  begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // all three slaves share one master; they answer on identical cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge aclk);
      if (awvalid && awready[0]) awvalid <= 1'h0;
      if (wvalid && wready[0]) wvalid <= 1'h0;
    end
    while (!bvalid[0]);
    for (int v = 0; v < 3; v++) wr_r[v] = bresp[v];
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready[0]) arvalid <= 1'h0;
    end
    while (!rvalid[0]);
    for (int v = 0; v < 3; v++) rd_d[v] = rdata[v];
    for (int v = 0; v < 3; v++) rd_r[v] = rresp[v];
    rready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    rd(a);
    for (int v = 0; v < 3; v++)
    begin
      chk("rdata", rd_d[v], e);
      chk("rresp", 32'(rd_r[v]), 32'(r));
    end
  endtask

  task automatic t_regs();
    rd_chk(SRC_SEL_OFS, 32'h0000_0000, RESP_OKAY);
    rd_chk(PA_FUNC_OFS, 32'h0000_0000, RESP_OKAY);
    for (int v = 0; v < 3; v++) chk("pa_func reset", 32'(pa_func[v]), 32'h0000_04a2);
    wr(SRC_SEL_OFS, 32'hffff_ffff, 4'hf);
    for (int v = 0; v < 3; v++) chk("bresp", 32'(wr_r[v]), 32'(RESP_OKAY));
    rd_chk(SRC_SEL_OFS, 32'h0000_003f, RESP_OKAY);
    wr(PA_FUNC_OFS, 32'h0000_00a5, 4'h1);
    rd_chk(PA_FUNC_OFS, 32'h0000_00a5, RESP_OKAY);
    // lane zero off: nothing may land
    wr(PA_FUNC_OFS, 32'h0000_005a, 4'he);
    rd_chk(PA_FUNC_OFS, 32'h0000_00a5, RESP_OKAY);
    wr(8'h08, 32'h0000_00ff, 4'hf);
    for (int v = 0; v < 3; v++) chk("bresp unmapped", 32'(wr_r[v]), 32'(RESP_SLVERR));
    rd_chk(8'h08, 32'h0000_0000, RESP_SLVERR);
    rd_chk(PA_FUNC_OFS, 32'h0000_00a5, RESP_OKAY);
    $display("test registers done");
  endtask

  task automatic t_route();
    logic [1:0] c [3];
    for (int k = 0; k < 4; k++)
    begin
      // fields get different codes so a swapped field shows up
      for (int j = 0; j < 3; j++) c[j] = 2'(k + j);
      wr(SRC_SEL_OFS, {26'h0, c[0], c[1], c[2]}, 4'h1);
      for (int p = 0; p < 10; p++)
      begin
        @(posedge aclk);
        pad_pat <= 10'(1 << p);
        repeat (3) @(posedge aclk);
        for (int v = 0; v < 3; v++)
        begin
          chk("sdi", 32'(sdi[v]), 32'(ROUTE[v][0][c[0]] == p));
          chk("sck", 32'(sck[v]), 32'(ROUTE[v][1][c[1]] == p));
          chk("rx", 32'(rx[v]), 32'(ROUTE[v][2][c[2]] == p));
        end
      end
    end
    $display("test routing done");
  endtask

  function automatic logic [10:0] exp_func(input int v, input logic [7:0] s);
    logic [10:0] f;
    f[10:8] = {s[7:6] == 2'h0 || s[7:6] == 2'h3, s[7:6] == 2'h1, s[7:6] == 2'h2};
    f[7:6] = (v == 0) ? 2'h2 : {s[5:4] != 2'h1, s[5:4] == 2'h1};
    f[5:2] = (v == 2) ? {s[3:2] != 2'h1, s[3:2] == 2'h1, 2'h0} :
      {s[3:2] == 2'h0, s[3:2] == 2'h1, s[3:2] == 2'h2, s[3:2] == 2'h3};
    f[1:0] = {s[1:0] != 2'h1, s[1:0] == 2'h1};
    return f;
  endfunction

  function automatic logic [3:0] exp_oe(input int v, input logic [7:0] s);
    logic [3:0] o;
    o = gpio_oe_n;
    if (s[1:0] == 2'h1) o[0] = 1'h0;
    if (s[3:2] == 2'h1) o[1] = 1'h0;
    if (v != 2 && s[3:2] == 2'h2) o[1] = 1'h1;
    if (v != 2 && s[3:2] == 2'h3) o[1] = periph.sck_oe_n;
    if (v != 0 && s[5:4] == 2'h1) o[2] = 1'h1;
    if (s[7:6] == 2'h1 || s[7:6] == 2'h2) o[3] = 1'h1;
    return o;
  endfunction

  function automatic logic [3:0] exp_out(input int v, input logic [7:0] s);
    logic [3:0] o;
    o = gpio_out;
    if (s[1:0] == 2'h1) o[0] = periph.sdo;
    if (s[3:2] == 2'h1) o[1] = periph.timer0;
    if (v != 2 && s[3:2] == 2'h3) o[1] = periph.sck;
    return o;
  endfunction

  task automatic t_func();
    logic [7:0] tbl [7] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h1b, 8'he4, 8'h9c};
    for (int i = 0; i < 7; i++)
    begin
      wr(PA_FUNC_OFS, {24'h0, tbl[i]}, 4'h1);
      gpio_out <= tbl[i][7:4];
      gpio_oe_n <= tbl[i][3:0] ^ 4'h6;
      per_pat <= tbl[i][3:0];
      repeat (4) @(posedge aclk);
      for (int v = 0; v < 3; v++)
      begin
        chk("pa_func", 32'(pa_func[v]), 32'(exp_func(v, tbl[i])));
        chk("pa_pad_oe_n", 32'(pa_pad_oe_n[v]), 32'(exp_oe(v, tbl[i])));
        chk("pa0 out", 32'(pa_pad_out[v][0]),
          32'(tbl[i][1:0] == 2'h1 ? periph.sdo : gpio_out[0]));
        chk("pa_pad_out", 32'(pa_pad_out[v]), 32'(exp_out(v, tbl[i])));
      end
    end
    $display("test pin functions done");
  endtask

  // clock enable low must freeze the routed inputs while the pads move
  task automatic t_hold();
    wr(SRC_SEL_OFS, 32'h0000_0000, 4'h1);
    pad_pat <= 10'h038;
    repeat (3) @(posedge aclk);
    ce <= 1'h0;
    pad_pat <= 10'h000;
    repeat (4) @(posedge aclk);
    for (int v = 0; v < 3; v++)
      chk("frozen route", 32'({sdi[v], sck[v], rx[v]}), 32'h0000_0007);
    ce <= 1'h1;
    repeat (3) @(posedge aclk);
    for (int v = 0; v < 3; v++)
      chk("resumed route", 32'({sdi[v], sck[v], rx[v]}), 32'h0000_0000);
    $display("test clock enable done");
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    aresetn = 1'h0;
    ce = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    gpio_out = 4'h0;
    gpio_oe_n = 4'hf;
    per_pat = 4'h0;
    pad_pat = 10'h038;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    for (int v = 0; v < 3; v++)
    begin
      chk("reset route", 32'({sdi[v], sck[v], rx[v]}), 32'h0000_0007);
    end
    t_regs();
    t_route();
    t_func();
    t_hold();
    results();
  end
endmodule // tb_pfsm_top
`default_nettype wire
